// ===== logic/ssp_regs.sv
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "ssp_cfg.svh"

module ssp_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire ssp_pkg::ssp_avm_req_t avm_req,
    output ssp_pkg::ssp_avm_rsp_t avm_rsp,
    input wire ssp_pkg::ssp_irq_vec_t raw_status,
    output ssp_pkg::ssp_irq_vec_t masked_irq_status,
    output logic irq,
    output logic presc_clk,
    output logic presc_tick
);
    import ssp_pkg::*;

    // ----------------------------------------
    // Module state
    // ----------------------------------------
    typedef struct packed {
        ssp_bus_state_t bus;
        logic [31:0] readdata;
        logic [7:0] prescale_divisor_field;
        ssp_irq_vec_t interrupt_mask;
        ssp_irq_vec_t events;
        ssp_irq_vec_t raw_prev;
        logic enable;
        logic irq;
    } ssp_regs_state_t;

    ssp_regs_state_t s_q;
    ssp_regs_state_t s_d;

    logic req;
    logic wr_take;
    logic rd_load;
    logic lane0;
    logic [7:0] presc_count;
    logic [3:0] raw_bits;
    logic [3:0] prev_bits;
    logic [3:0] evt_bits;
    logic [3:0] evt_clr;
    logic [3:0] evt_next;
    logic [3:0] mis_bits;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle per access lets read data come from a flip-flop
    assign req = avm_req.read | avm_req.write;
    assign rd_load = avm_req.read && (s_q.bus == SSP_BUS_IDLE);
    assign wr_take = avm_req.write && (s_q.bus == SSP_BUS_ACK);
    assign lane0 = avm_req.byteenable[0];

    assign raw_bits = raw_status;
    assign prev_bits = s_q.raw_prev;
    assign evt_bits = s_q.events;

    assign mis_bits = raw_bits & s_q.interrupt_mask;

    assign evt_clr = (wr_take && lane0 && avm_req.address == `SSP_OFS_EVT_STAT) ?
        avm_req.writedata[3:0] : 4'h0;

    // ----------------------------------------
    // Sticky event bits
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SSP_IRQ_W; gi = gi + 1) begin : g_evt
            // Set beats a clear landing in the same cycle
            assign evt_next[gi] = (raw_bits[gi] && !prev_bits[gi]) ||
                (evt_bits[gi] && !evt_clr[gi]);
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avm_req.address)
            `SSP_OFS_PRESCALE: rd_mux = {24'h00_0000, s_q.prescale_divisor_field};
            `SSP_OFS_IRQ_MASK: rd_mux = {28'h000_0000, s_q.interrupt_mask};
            `SSP_OFS_RAW_STAT: rd_mux = {28'h000_0000, raw_bits};
            `SSP_OFS_MASK_STAT: rd_mux = {28'h000_0000, mis_bits};
            `SSP_OFS_EVT_STAT: rd_mux = {28'h000_0000, evt_bits};
            `SSP_OFS_CONTROL: rd_mux = {31'h0000_0000, s_q.enable};
            `SSP_OFS_PRESC_CNT: rd_mux = {24'h00_0000, presc_count};
            // Unmapped or unaligned addresses read as zero
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.bus)
            SSP_BUS_IDLE: begin
                if (req) begin
                    s_d.bus = SSP_BUS_ACK;
                end
            end
            SSP_BUS_ACK: begin
                s_d.bus = SSP_BUS_IDLE;
            end
            default: begin
                s_d.bus = SSP_BUS_IDLE;
            end
        endcase
        if (rd_load) begin
            s_d.readdata = rd_mux;
        end
        if (wr_take && lane0) begin
            case (avm_req.address)
                `SSP_OFS_PRESCALE: begin
                    s_d.prescale_divisor_field = avm_req.writedata[7:0] & `SSP_DIV_LSB_MASK;
                end
                `SSP_OFS_IRQ_MASK: begin
                    s_d.interrupt_mask = avm_req.writedata[3:0];
                end
                `SSP_OFS_CONTROL: begin
                    s_d.enable = avm_req.writedata[`SSP_CTRL_EN_BIT];
                end
                default: begin
                    s_d.enable = s_q.enable;
                end
            endcase
        end
        s_d.raw_prev = raw_status;
        s_d.events = evt_next;
        s_d.irq = |(s_d.interrupt_mask & (raw_bits | evt_next));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.bus <= SSP_BUS_IDLE;
            s_q.readdata <= 32'h0000_0000;
            s_q.prescale_divisor_field <= `SSP_RST_PRESCALE;
            s_q.interrupt_mask <= `SSP_RST_IRQ_MASK;
            s_q.events <= 4'h0;
            s_q.raw_prev <= 4'h0;
            s_q.enable <= `SSP_RST_CONTROL;
            s_q.irq <= 1'b0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // divisor feeds the prescaler
    ssp_prescaler u_presc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(s_q.enable),
        .divisor(s_q.prescale_divisor_field),
        .presc_clk(presc_clk),
        .presc_tick(presc_tick),
        .presc_count(presc_count)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign avm_rsp = '{readdata: s_q.readdata, waitrequest: req && (s_q.bus == SSP_BUS_IDLE)};
    assign masked_irq_status = mis_bits;
    assign irq = s_q.irq;
endmodule

// ===== logic/ssp_cfg.svh
// Function
// - Clock is divided by the programmed prescale divisor before bit clock division.
// - Divisor bit zero is forced to zero on write and on read-back.
// - Reset clears all four interrupt mask bits, so every source starts masked.
// - Reading the mask register returns the mask currently held per source.
// - Writing 1 sets a mask bit, writing 0 clears it; plain storage.
// - Mask bit 3 tx half-empty, 2 rx half-full, 1 rx timeout, 0 overrun.
// - A mask bit of 1 passes its source on, 0 blocks it.
// - Masked status equals raw status AND mask, readable in its own register.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SSP_OFS_PRESCALE 8'h10
`define SSP_OFS_IRQ_MASK 8'h14
`define SSP_OFS_RAW_STAT 8'h18
`define SSP_OFS_MASK_STAT 8'h1C
`define SSP_OFS_EVT_STAT 8'h20
`define SSP_OFS_CONTROL 8'h24
`define SSP_OFS_PRESC_CNT 8'h28

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SSP_DIV_W 8
`define SSP_IRQ_W 4
`define SSP_DIV_LSB_MASK 8'hFE
`define SSP_RST_PRESCALE 8'h00
`define SSP_RST_IRQ_MASK 4'h0
`define SSP_RST_CONTROL 1'h0
`define SSP_CTRL_EN_BIT 0
`define SSP_ADDR_W 8
`define SSP_DATA_W 32

`endif

// ===== logic/ssp_pkg.sv
package ssp_pkg;

    // ----------------------------------------
    // Bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ssp_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ssp_avm_rsp_t;

    // ----------------------------------------
    // Interrupt source vector, bit 3 down to 0
    // ----------------------------------------
    typedef struct packed {
        logic tx_half_empty;
        logic rx_half_full;
        logic rx_timeout;
        logic rx_overrun;
    } ssp_irq_vec_t;

    typedef enum logic [0:0] {
        SSP_BUS_IDLE = 1'b0,
        SSP_BUS_ACK = 1'b1
    } ssp_bus_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic level;
        logic tick;
    } ssp_presc_state_t;

endpackage

// ===== logic/ssp_prescaler.sv
`timescale 1ns/100ps
`include "ssp_cfg.svh"

module ssp_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic [7:0] divisor,
    output logic presc_clk,
    output logic presc_tick,
    output logic [7:0] presc_count
);
    import ssp_pkg::*;

    ssp_presc_state_t s_q;
    ssp_presc_state_t s_d;
    logic [7:0] half;
    logic run;

    // Divisor is even, so each half period is exactly divisor/2 cycles
    assign half = {1'b0, divisor[7:1]};
    // Divisors below 2 stop the prescaler rather than run at an odd rate
    assign run = enable && (half != 8'h00);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.count = 8'h00;
            s_d.level = 1'b0;
        // divide by divisor
        // Greater-or-equal so a smaller new divisor never waits out a wrap
        end else if (s_q.count >= half - 8'h01) begin
            s_d.count = 8'h00;
            s_d.level = ~s_q.level;
            s_d.tick = ~s_q.level;
        end else begin
            s_d.count = s_q.count + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign presc_clk = s_q.level;
    assign presc_tick = s_q.tick;
    assign presc_count = s_q.count;
endmodule

// ===== tb/ssp_regs_checker.sv
`timescale 1ns/100ps
module ssp_regs_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire ssp_pkg::ssp_avm_req_t avm_req,
    input wire ssp_pkg::ssp_avm_rsp_t avm_rsp,
    input wire ssp_pkg::ssp_irq_vec_t raw_status,
    input wire ssp_pkg::ssp_irq_vec_t masked_irq_status,
    input wire logic irq,
    input wire logic presc_clk,
    input wire logic presc_tick
);
    import ssp_pkg::*;
    logic [3:0] mask_q;
    logic [7:0] div_q;
    logic done;
    assign done = (avm_req.read | avm_req.write) & ~avm_rsp.waitrequest & ce;
    // Shadow of what software wrote
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 4'h0;
            div_q <= 8'h00;
        end else if (done && avm_req.write && avm_req.byteenable[0]) begin
            if (avm_req.address == 8'h14) begin
                mask_q <= avm_req.writedata[3:0];
            end
            if (avm_req.address == 8'h10) begin
                div_q <= avm_req.writedata[7:0] & 8'hFE;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rd_done(a);
        done && avm_req.read && avm_req.address == a;
    endsequence
    mask_pass_a: assert property (masked_irq_status == (raw_status & mask_q))
        else $error("masked status differs");
    overrun_bit_a: assert property (
        masked_irq_status.rx_overrun == (raw_status.rx_overrun & mask_q[0]))
        else $error("overrun bit misplaced");
    mask_read_a: assert property (rd_done(8'h14) |-> avm_rsp.readdata == {28'h0, mask_q})
        else $error("mask readback wrong");
    div_read_a: assert property (rd_done(8'h10) |-> avm_rsp.readdata == {24'h0, div_q})
        else $error("divisor readback wrong");
    stat_read_a: assert property (
        rd_done(8'h1C) |-> avm_rsp.readdata == {28'h0, $past(raw_status) & mask_q})
        else $error("masked status read wrong");
    reset_clear_a: assert property ($rose(rst_n) |-> masked_irq_status == 4'h0 && !irq)
        else $error("mask not clear after reset");
    irq_raise_a: assert property (ce && masked_irq_status != 4'h0 &&
        !(done && avm_req.write && avm_req.address == 8'h14) |=> irq)
        else $error("irq missing");
    tick_gap_a: assert property (presc_tick && ce |=> !presc_tick)
        else $error("prescale tick too long");
    tick_edge_a: assert property ($rose(presc_clk) |-> presc_tick)
        else $error("prescale tick not at clock rise");
endmodule

bind ssp_regs ssp_regs_checker ssp_regs_checker_i (.clk, .rst_n, .ce, .avm_req, .avm_rsp,
    .raw_status, .masked_irq_status, .irq, .presc_clk, .presc_tick);

// ===== tb/tb_ssp_regs.sv
`timescale 1ns/100ps
module tb_ssp_regs;
    import ssp_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, irq, pclk, tick;
    ssp_avm_req_t req = '0;
    ssp_avm_rsp_t rsp;
    ssp_irq_vec_t raw = '0, mis;
    int bad_count, check_count, p;
    logic [31:0] rd, v;
    logic [7:0] dl [5] = '{8'h07, 8'h02, 8'hFF, 8'h0C, 8'h00};
    ssp_regs ssp_regs_i (.clk(clk), .rst_n(rst_n), .ce(ce), .avm_req(req), .avm_rsp(rsp),
        .raw_status(raw), .masked_irq_status(mis), .irq(irq), .presc_clk(pclk),
        .presc_tick(tick));
    initial forever #20 clk = ~clk;
    task conclude;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic [31:0] exp_div(input logic [7:0] d);
        return {24'h0, d & 8'hFE};
    endfunction
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
        // Only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task gap;
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (tick !== 1'b1 && p < 600);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end
    initial begin
        v = $urandom(87186);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 8'h14, 0); check("mask", rd, 0);
        bus(0, 8'h10, 0); check("div", rd, 0);
        for (int i = 0; i < 4; i++) begin
            v = ($urandom & 32'hFFFF_FFF0) | (32'h1 << i);
            raw <= 4'($urandom) | 4'(1 << i);
            bus(1, 8'h14, v);
            bus(0, 8'h14, 0); check("mask bit", rd, 32'h1 << i);
            check("irq", irq, 1);
            bus(0, 8'h1C, 0); check("mis read", rd, 32'h1 << i);
        end
        repeat (6) begin
            v = $urandom;
            raw <= 4'($urandom);
            bus(1, 8'h14, v);
            bus(0, 8'h14, 0); check("mask", rd, v & 32'hF);
            check("mis", mis, raw & v[3:0]);
        end
        bus(1, 8'h14, 0); bus(0, 8'h14, 0); check("mask", rd, 0);
        check("irq off", irq, 0);
        raw <= 4'h0;
        bus(1, 8'h20, 32'hF); bus(1, 8'h14, 32'h1); check("irq", irq, 0);
        raw <= 4'h1;
        bus(0, 8'h14, 0); check("irq", irq, 1);
        raw <= 4'h0;
        bus(1, 8'h20, 32'h1); bus(0, 8'h10, 0); check("irq", irq, 0);
        bus(1, 8'h24, 32'h1);
        dl[4] = 8'(2 * ($urandom % 10 + 1));
        for (int k = 0; k < 5; k++) begin
            bus(1, 8'h10, {24'($urandom), dl[k]});
            bus(0, 8'h10, 0); check("div", rd, exp_div(dl[k]));
            gap(); gap(); gap(); check("period", p, exp_div(dl[k]));
        end
        // Clock enable low freezes the prescaler
        ce <= 1'b0;
        @(posedge clk);
        v[0] = pclk;
        repeat (12) @(posedge clk);
        check("frozen", pclk, v[0]);
        ce <= 1'b1;
        bus(1, 8'h3C, 32'hFFFF_FFFF); bus(0, 8'h3C, 0); check("unmapped", rd, 0);
        conclude();
    end
endmodule
